//--- testbench/host_pin_sampler.sv
/*
  Host side of the interrupt pins: resolves each wire from value and enable.
  Assumes the block clock; pin A has a pull-up in shared style only.
*/
`timescale 1ns/1ps
module host_pin_sampler (
  // Clock and mode
  input wire       clk,
  input wire       busStyleStrobe,
  // Pins
  input wire [3:0] pinOut,
  input wire [3:0] pinOe,
  // Resolved levels
  output reg [3:0] level
);
  reg [3:0] last = 4'h0;
  integer i;
  always @(posedge clk) begin
    last <= level;
  end
  // A floating wire toggles so a stale value never passes for a drive
  always @* begin
    for (i = 0; i < 4; i = i + 1) begin
      if (pinOe[i])
        level[i] = pinOut[i];
      else if (i == 0 && !busStyleStrobe)
        level[i] = 1'h1;
      else
        level[i] = ~last[i];
    end
  end
endmodule

//--- testbench/quad_irq_checker.sv
/*
  Concurrent checks on the interrupt pins, ready flags and bus answer.
  Bound to the top module; sees its ports only.
*/
`timescale 1ns/1ps
module quad_irq_checker #(
  parameter SEL_PIN_PRESENT = 1
) (
  // Clock and reset
  input wire        clk,
  input wire        resetn,
  // Bus
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [7:0]  wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  // Mode and cores
  input wire        busStyleStrobe,
  input wire        irqAlwaysOnSelect,
  input wire [3:0]  chanIrqPending,
  // Interrupt pins
  input wire        chanAIrqOut,
  input wire        chanAIrqOe,
  input wire        chanBIrqOut,
  input wire        chanBIrqOe,
  input wire        chanCIrqOut,
  input wire        chanCIrqOe,
  input wire        chanDIrqOut,
  input wire        chanDIrqOe,
  // Ready pins
  input wire        chanATxReadyN,
  input wire        chanBTxReadyN,
  input wire        chanCTxReadyN,
  input wire        chanDTxReadyN,
  input wire        chanARxReadyN,
  input wire        chanBRxReadyN,
  input wire        chanCRxReadyN,
  input wire        chanDRxReadyN,
  input wire        anyTxReadyN,
  input wire        anyRxReadyN
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire [3:0] pOut = {chanDIrqOut, chanCIrqOut, chanBIrqOut, chanAIrqOut};
  wire [3:0] pOe  = {chanDIrqOe, chanCIrqOe, chanBIrqOe, chanAIrqOe};
  always_on_a: assert property (
    busStyleStrobe && irqAlwaysOnSelect && SEL_PIN_PRESENT != 0 |=> pOe == 4'hF) else $error("Pins not enabled");
  pin_follow_a: assert property (
    busStyleStrobe |=> pOut == $past(chanIrqPending)) else $error("Pin value not pending");
  spare_low_a: assert property (
    !busStyleStrobe |=> pOe[3:1] == 3'h7 && pOut[3:1] == 3'h0) else $error("Spare pins not low");
  shared_drain_a: assert property (
    !busStyleStrobe |=> !chanAIrqOut) else $error("Shared pin driven high");
  any_tx_a: assert property (
    anyTxReadyN == (chanATxReadyN & chanBTxReadyN & chanCTxReadyN & chanDTxReadyN)) else $error("Tx AND wrong");
  any_rx_a: assert property (
    anyRxReadyN == (chanARxReadyN & chanBRxReadyN & chanCRxReadyN & chanDRxReadyN)) else $error("Rx AND wrong");
  ack_time_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("Ack late");
  ack_pulse_a: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("Ack too long");
  hole_read_a: assert property (
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) >= 8'h30 |-> wb_dat_o == 32'h0) else $error("Hole read");
endmodule
bind quad_uart_irq_ready_outputs quad_irq_checker #(.SEL_PIN_PRESENT(SEL_PIN_PRESENT)) chk (.*);

//--- testbench/quad_uart_irq_ready_outputs_bench.sv
/*
  Bench: Wishbone tasks and pin checks for the interrupt and ready outputs.
  Assumes the design files and the host pin sampler are compiled first.
*/
`timescale 1ns/1ps
module quad_uart_irq_ready_outputs_bench;
  reg         clk = 0, resetn = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  reg  [7:0]  wb_adr_i = 8'h00;
  reg  [31:0] wb_dat_i = 32'h0, rd;
  reg         strobe = 1, alwaysOn = 0;
  reg  [3:0]  pend = 4'h0, tmo = 4'h0, wb_sel_i = 4'h0, wrSel = 4'hF;
  reg  [27:0] txL = 28'h0, rxL = 28'h0;
  wire [31:0] wb_dat_o;
  wire        wb_ack_o, irq, anyTx, anyRx;
  wire [3:0]  pOut, pOe, txN, rxN, lvl, oeT;
  integer     nFail = 0, testsRun = 0, k;
  always #20 clk = ~clk;
  quad_uart_irq_ready_outputs DUT (.clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .busStyleStrobe(strobe), .irqAlwaysOnSelect(alwaysOn), .chanIrqPending(pend),
    .txLevel(txL), .rxLevel(rxL), .rxTimeout(tmo), .chanAIrqOut(pOut[0]), .chanAIrqOe(pOe[0]),
    .chanBIrqOut(pOut[1]), .chanBIrqOe(pOe[1]), .chanCIrqOut(pOut[2]), .chanCIrqOe(pOe[2]),
    .chanDIrqOut(pOut[3]), .chanDIrqOe(pOe[3]), .chanATxReadyN(txN[0]), .chanBTxReadyN(txN[1]),
    .chanCTxReadyN(txN[2]), .chanDTxReadyN(txN[3]), .chanARxReadyN(rxN[0]), .chanBRxReadyN(rxN[1]),
    .chanCRxReadyN(rxN[2]), .chanDRxReadyN(rxN[3]), .anyTxReadyN(anyTx), .anyRxReadyN(anyRx), .irq(irq));
  host_pin_sampler HOST (.clk(clk), .busStyleStrobe(strobe), .pinOut(pOut), .pinOe(pOe), .level(lvl));
  // Pinless build bonded high: in strobe style pins enabled whatever the enable bits and the select input say
  quad_uart_irq_ready_outputs #(.SEL_PIN_PRESENT(0), .SEL_TIED_LEVEL(1)) TIED (.clk(clk), .resetn(resetn),
    .wb_cyc_i(1'b0), .wb_stb_i(1'b0), .wb_we_i(1'b0), .wb_adr_i(8'h00), .wb_sel_i(4'h0), .wb_dat_i(32'h0),
    .wb_dat_o(), .wb_ack_o(), .busStyleStrobe(strobe), .irqAlwaysOnSelect(alwaysOn), .chanIrqPending(pend),
    .txLevel(txL), .rxLevel(rxL), .rxTimeout(tmo), .chanAIrqOut(), .chanAIrqOe(oeT[0]), .chanBIrqOut(),
    .chanBIrqOe(oeT[1]), .chanCIrqOut(), .chanCIrqOe(oeT[2]), .chanDIrqOut(), .chanDIrqOe(oeT[3]),
    .chanATxReadyN(), .chanBTxReadyN(), .chanCTxReadyN(), .chanDTxReadyN(), .chanARxReadyN(), .chanBRxReadyN(),
    .chanCRxReadyN(), .chanDRxReadyN(), .anyTxReadyN(), .anyRxReadyN(), .irq());
  task testDone;
    begin
      $display("Checks %0d, failures %0d", testsRun, nFail);
      if (nFail == 0 && testsRun > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      testsRun++;
      if (seen !== exp) begin
        nFail++;
        $display("Error %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // Request held until ack is sampled; bounded wait
  task wb(input w, input [7:0] a, input [31:0] d);
    integer i;
    begin
      @(posedge clk);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'h3, w, a, d, wrSel};
      i = 0;
      do begin
        @(posedge clk);
        i++;
      end while (wb_ack_o !== 1'h1 && i < 50);
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'h0;
      if (wb_ack_o !== 1'h1) begin
        nFail++;
        testDone;
      end
    end
  endtask
  task rdChk(input [7:0] a, input [31:0] e, input string nm);
    begin
      wb(0, a, 32'h0);
      chk(nm, rd, e);
    end
  endtask
  // Pins are registered: two edges, then sample mid-cycle
  task step;
    begin
      repeat (2) @(posedge clk);
      @(negedge clk);
    end
  endtask
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1;
    rdChk(8'h00, 32'h0, "modemA");
    rdChk(8'h2C, 32'h0, "evtEnable");
    rdChk(8'h40, 32'h0, "unmapped");
    rdChk(8'h20, 32'h80F0, "pinStatus");
    // A write without the low byte lane must leave the register alone
    wrSel <= 4'hE;
    wb(1, 8'h0C, 32'h08);
    wrSel <= 4'hF;
    rdChk(8'h0C, 32'h0, "selIgnored");
    wb(1, 8'h04, 32'h08);
    step;
    chk("oeB", pOe, 4'h2);
    chk("oeTied", oeT, 4'hF);
    @(posedge clk);
    pend <= 4'hA;
    wb(1, 8'h00, 32'h08);
    step;
    chk("oeA", pOe, 4'h3);
    chk("levels", lvl[1:0], 2'h2);
    @(posedge clk);
    alwaysOn <= 1;
    step;
    chk("oeAll", {pOe, pOut}, 8'hFA);
    @(posedge clk);
    alwaysOn <= 0;
    step;
    chk("oeMcr", pOe, 4'h3);
    @(posedge clk);
    strobe <= 0;
    pend <= 4'h1;
    step;
    chk("sharedDrv", {pOe, pOut, lvl[0]}, 9'h1E0);
    @(posedge clk);
    pend <= 4'h4;
    step;
    chk("sharedIdle", {pOe, pOut, lvl[0]}, 9'h1C1);
    @(posedge clk);
    strobe <= 1;
    pend <= 4'h0;
    wb(1, 8'h2C, 32'h04);
    txL <= {4{7'h01}};
    rxL <= {7'h00, 7'h01, 14'h0};
    step;
    chk("ready", {txN, anyTx, rxN, anyRx}, 10'h3F6);
    chk("irq", irq, 1'h1);
    // Tx flags fell from their reset level just after reset, so those events stand too
    rdChk(8'h24, 32'hF4, "evtStatus");
    wb(1, 8'h2C, 32'h00);
    step;
    chk("irqMasked", irq, 1'h0);
    wb(1, 8'h28, 32'h04);
    rdChk(8'h24, 32'hF0, "evtCleared");
    txL[13:7] <= 7'h00;
    step;
    chk("anyTxOne", {txN, anyTx}, 5'h1A);
    // Multi transfer on channel A, trigger 8 both ways; hold cases in between
    wb(1, 8'h10, 32'h09);
    for (k = 0; k < 5; k++) begin
      txL[6:0] <= {7'h40, 7'h3C, 7'h38, 7'h3C, 7'h40} >> (7 * k);
      rxL[6:0] <= {7'h01, 7'h00, 7'h04, 7'h08, 7'h04} >> (7 * k);
      tmo[0] <= (k == 4);
      step;
      chk("multi", {txN[0], rxN[0]}, (10'h24B >> (2 * k)) & 10'h003);
      @(posedge clk);
    end
    testDone;
  end
endmodule

//--- verilog/fifo_ready_flag.v
/*
  One channel's active-low transmit-ready and receive-ready flags, derived from FIFO fill
  levels, trigger levels and the single or multi transfer mode.
  Assumes fill levels and timeout come synchronously from the channel's FIFO logic.
*/
`timescale 1ns/1ps
module fifo_ready_flag #(
  parameter DEPTH = 64,
  parameter LW    = 7
) (
  // Clock and reset
  input  wire          clk,
  input  wire          resetn,
  // Channel configuration
  input  wire          fifoEnable,
  input  wire          dmaMode,
  input  wire [LW-1:0] txTrigger,
  input  wire [LW-1:0] rxTrigger,
  // Channel state
  input  wire [LW-1:0] txLevel,
  input  wire [LW-1:0] rxLevel,
  input  wire          rxTimeout,
  // Ready flags
  output reg           txReadyN,
  output reg           rxReadyN
);

  localparam [LW-1:0] FULL = DEPTH;

  wire multi = fifoEnable & dmaMode;
  reg  next_txReadyN;
  reg  next_rxReadyN;

  always @* begin
    next_txReadyN = txReadyN;
    next_rxReadyN = rxReadyN;
    if (!multi) begin
      // Single transfer: ready while the holding side is empty or holds data
      next_txReadyN = (txLevel != {LW{1'b0}});
      next_rxReadyN = (rxLevel == {LW{1'b0}});
    end else begin
      // Multi transfer keeps hysteresis so the host drains or fills in bursts
      if (txLevel == FULL)
        next_txReadyN = 1'b1;
      else if ((FULL - txLevel) >= txTrigger)
        next_txReadyN = 1'b0;
      if (rxLevel == {LW{1'b0}})
        next_rxReadyN = 1'b1;
      else if (rxLevel >= rxTrigger || rxTimeout)
        next_rxReadyN = 1'b0;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      txReadyN <= 1'b1;
      rxReadyN <= 1'b1;
    end else begin
      txReadyN <= next_txReadyN;
      rxReadyN <= next_rxReadyN;
    end
  end

endmodule

//--- verilog/irq_pin_gate.v
/*
  One interrupt pin: enable gating by bus style, always-on select and the modem control
  enable bit, with tri-state or open-drain drive as two separate signals.
  Assumes a pad or testbench resolves the wire level from out and oe.
*/
`timescale 1ns/1ps
module irq_pin_gate #(
  parameter IS_CHAN_A = 0
) (
  // Clock and reset
  input  wire clk,
  input  wire resetn,
  // Controls
  input  wire strobeBus,
  input  wire alwaysOn,
  input  wire irqEnable,
  input  wire irqPending,
  input  wire deviceIrq,
  // Pin
  output reg  pinOut,
  output reg  pinOe
);

  reg next_pinOut;
  reg next_pinOe;

  always @* begin
    if (strobeBus) begin
      next_pinOe  = alwaysOn | irqEnable;
      next_pinOut = irqPending;
    end else if (IS_CHAN_A != 0) begin
      // Open drain: only ever pulls low
      next_pinOe  = deviceIrq;
      next_pinOut = 1'b0;
    end else begin
      next_pinOe  = 1'b1;
      next_pinOut = 1'b0;
    end
  end

  // Reset leaves the pin released, matching a cleared enable bit
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pinOut <= 1'b0;
      pinOe  <= 1'b0;
    end else begin
      pinOut <= next_pinOut;
      pinOe  <= next_pinOe;
    end
  end

endmodule

//--- verilog/quad_irq_defs.vh
/*
  Shared constants of the quad UART interrupt and ready pin block: register byte offsets,
  field positions, reset values and trigger level figures.
  Assumes inclusion by bare name from the design files; definitions only.
*/
`ifndef QUAD_IRQ_DEFS_VH
`define QUAD_IRQ_DEFS_VH

// Register byte offsets, one 32-bit word each
`define OFS_MODEM_CTRL0   8'h00
`define OFS_FIFO_CTRL0    8'h10
`define OFS_PIN_STATUS    8'h20
`define OFS_EVT_STATUS    8'h24
`define OFS_EVT_CLEAR     8'h28
`define OFS_EVT_ENABLE    8'h2C

// Modem control field
`define MCR_IRQ_EN_BIT    3
`define MCR_RESET         8'h00

// FIFO control fields
`define FCR_FIFO_EN_BIT   0
`define FCR_DMA_MODE_BIT  3
`define FCR_TX_TRIG_LO    4
`define FCR_RX_TRIG_LO    6
`define FCR_RESET         8'h00

// Trigger level figures, selected by a two-bit field
`define TX_TRIG_0         7'h08
`define TX_TRIG_1         7'h10
`define TX_TRIG_2         7'h20
`define TX_TRIG_3         7'h38
`define RX_TRIG_0         7'h08
`define RX_TRIG_1         7'h10
`define RX_TRIG_2         7'h38
`define RX_TRIG_3         7'h3C

// Event register layout
`define EVT_WIDTH         8
`define EVT_RESET         8'h00

`endif

//--- verilog/quad_uart_irq_ready_outputs.v
/*
  Interrupt and FIFO-ready output pins of a four-channel UART, with per-channel modem and
  FIFO control registers, pin status readback and an event interrupt, on a classic
  Wishbone slave.
  Assumes all inputs are synchronous to clk and that the channel cores supply pending
  interrupts, FIFO fill levels and receive timeouts.
*/
// Contract
// - In strobe style the channel A interrupt pin is driven when its enable bit is one.
// - In strobe style with a low always-on select and the enable bit at its reset value zero the channel A pin floats.
// - In read/write-line style channel A carries one shared active-low open-drain interrupt.
// - In strobe style with a low always-on select pins B, C and D are driven or floated by their own enable bits.
// - In read/write-line style pins B, C and D are driven steadily low.
// - A high always-on select in strobe style enables every interrupt pin regardless of the bit.
// - A low always-on select in strobe style leaves each pin to its enable bit, one meaning driven.
// - Without the select pin, the device acts as if it were tied high in one build, low in the other.
// - Each channel has an active-low transmit-ready output from its transmit FIFO state.
// - Each channel has an active-low receive-ready output from its receive FIFO state.
// - The combined transmit-ready output is the AND of the four channel flags.
// - The combined receive-ready output is the AND of the four channel flags.
`timescale 1ns/1ps
`include "quad_irq_defs.vh"
module quad_uart_irq_ready_outputs #(
  parameter SEL_PIN_PRESENT = 1,
  parameter SEL_TIED_LEVEL  = 0,
  parameter DEPTH           = 64,
  parameter LW              = 7
) (
  // Clock and reset
  input  wire           clk,
  input  wire           resetn,
  // Wishbone slave
  input  wire           wb_cyc_i,
  input  wire           wb_stb_i,
  input  wire           wb_we_i,
  input  wire [7:0]     wb_adr_i,
  input  wire [3:0]     wb_sel_i,
  input  wire [31:0]    wb_dat_i,
  output reg  [31:0]    wb_dat_o,
  output reg            wb_ack_o,
  // Mode pins
  input  wire           busStyleStrobe,
  input  wire           irqAlwaysOnSelect,
  // Channel cores, channel A in bit 0
  input  wire [3:0]     chanIrqPending,
  input  wire [4*LW-1:0] txLevel,
  input  wire [4*LW-1:0] rxLevel,
  input  wire [3:0]     rxTimeout,
  // Interrupt pins
  output wire           chanAIrqOut,
  output wire           chanAIrqOe,
  output wire           chanBIrqOut,
  output wire           chanBIrqOe,
  output wire           chanCIrqOut,
  output wire           chanCIrqOe,
  output wire           chanDIrqOut,
  output wire           chanDIrqOe,
  // Ready pins
  output wire           chanATxReadyN,
  output wire           chanBTxReadyN,
  output wire           chanCTxReadyN,
  output wire           chanDTxReadyN,
  output wire           chanARxReadyN,
  output wire           chanBRxReadyN,
  output wire           chanCRxReadyN,
  output wire           chanDRxReadyN,
  output wire           anyTxReadyN,
  output wire           anyRxReadyN,
  // Event interrupt
  output wire           irq
);

  reg  [7:0] modemControlReg [0:3];
  reg  [7:0] fifoControl     [0:3];
  reg  [`EVT_WIDTH-1:0] evtStatus;
  reg  [`EVT_WIDTH-1:0] evtEnable;
  reg  [3:0] txReadyPrev;
  reg  [3:0] rxReadyPrev;
  wire [3:0] txReadyN;
  wire [3:0] rxReadyN;
  wire [3:0] pinOut;
  wire [3:0] pinOe;
  wire [3:0] irqEnable;

  function [LW-1:0] txTrigOf;
    input [1:0] code;
    begin
      case (code)
        2'h0:    txTrigOf = `TX_TRIG_0;
        2'h1:    txTrigOf = `TX_TRIG_1;
        2'h2:    txTrigOf = `TX_TRIG_2;
        default: txTrigOf = `TX_TRIG_3;
      endcase
    end
  endfunction

  function [LW-1:0] rxTrigOf;
    input [1:0] code;
    begin
      case (code)
        2'h0:    rxTrigOf = `RX_TRIG_0;
        2'h1:    rxTrigOf = `RX_TRIG_1;
        2'h2:    rxTrigOf = `RX_TRIG_2;
        default: rxTrigOf = `RX_TRIG_3;
      endcase
    end
  endfunction

  // Builds without the select pin ignore it and use the bonded level
  wire selLevel  = (SEL_PIN_PRESENT != 0) ? irqAlwaysOnSelect : (SEL_TIED_LEVEL != 0);
  // Honoured only in strobe style; the host keeps it low otherwise
  wire alwaysOn  = busStyleStrobe & selLevel;
  // Shared device interrupt for the read/write-line style
  wire deviceIrq = |(chanIrqPending & irqEnable);

  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1) begin : gChan
      assign irqEnable[ch] = modemControlReg[ch][`MCR_IRQ_EN_BIT];

      irq_pin_gate #(
        .IS_CHAN_A (ch == 0)
      ) uGate (
        .clk        (clk),
        .resetn     (resetn),
        .strobeBus  (busStyleStrobe),
        .alwaysOn   (alwaysOn),
        .irqEnable  (irqEnable[ch]),
        .irqPending (chanIrqPending[ch]),
        .deviceIrq  (deviceIrq),
        .pinOut     (pinOut[ch]),
        .pinOe      (pinOe[ch])
      );

      fifo_ready_flag #(
        .DEPTH (DEPTH),
        .LW    (LW)
      ) uReady (
        .clk        (clk),
        .resetn     (resetn),
        .fifoEnable (fifoControl[ch][`FCR_FIFO_EN_BIT]),
        .dmaMode    (fifoControl[ch][`FCR_DMA_MODE_BIT]),
        .txTrigger  (txTrigOf(fifoControl[ch][`FCR_TX_TRIG_LO+1:`FCR_TX_TRIG_LO])),
        .rxTrigger  (rxTrigOf(fifoControl[ch][`FCR_RX_TRIG_LO+1:`FCR_RX_TRIG_LO])),
        .txLevel    (txLevel[ch*LW +: LW]),
        .rxLevel    (rxLevel[ch*LW +: LW]),
        .rxTimeout  (rxTimeout[ch]),
        .txReadyN   (txReadyN[ch]),
        .rxReadyN   (rxReadyN[ch])
      );
    end
  endgenerate

  assign chanAIrqOut = pinOut[0];
  assign chanAIrqOe  = pinOe[0];
  assign chanBIrqOut = pinOut[1];
  assign chanBIrqOe  = pinOe[1];
  assign chanCIrqOut = pinOut[2];
  assign chanCIrqOe  = pinOe[2];
  assign chanDIrqOut = pinOut[3];
  assign chanDIrqOe  = pinOe[3];

  assign chanATxReadyN = txReadyN[0];
  assign chanBTxReadyN = txReadyN[1];
  assign chanCTxReadyN = txReadyN[2];
  assign chanDTxReadyN = txReadyN[3];
  assign chanARxReadyN = rxReadyN[0];
  assign chanBRxReadyN = rxReadyN[1];
  assign chanCRxReadyN = rxReadyN[2];
  assign chanDRxReadyN = rxReadyN[3];
  // Gates of flop outputs only, so no glitch path from the FIFOs
  assign anyTxReadyN = &txReadyN;
  assign anyRxReadyN = &rxReadyN;

  // Wishbone decode: one wait state, ack drops the cycle after it rises
  wire       req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire       wrLow   = req & wb_we_i & wb_sel_i[0];
  wire [1:0] chIdx   = wb_adr_i[3:2];
  wire       hitMcr  = (wb_adr_i[7:4] == `OFS_MODEM_CTRL0 >> 4) & (wb_adr_i[1:0] == 2'h0);
  wire       hitFcr  = (wb_adr_i[7:4] == `OFS_FIFO_CTRL0 >> 4) & (wb_adr_i[1:0] == 2'h0);
  wire       wrClear = wrLow & (wb_adr_i == `OFS_EVT_CLEAR);

  // Ready flags turning active are the events
  wire [`EVT_WIDTH-1:0] evtSet = {txReadyPrev & ~txReadyN, rxReadyPrev & ~rxReadyN};
  wire [`EVT_WIDTH-1:0] evtClr = wrClear ? wb_dat_i[`EVT_WIDTH-1:0] : {`EVT_WIDTH{1'b0}};

  assign irq = |(evtStatus & evtEnable);

  reg [31:0] rdData;
  always @* begin
    rdData = 32'h0000_0000;
    if (hitMcr)
      rdData[7:0] = modemControlReg[chIdx];
    else if (hitFcr)
      rdData[7:0] = fifoControl[chIdx];
    else if (wb_adr_i == `OFS_PIN_STATUS)
      rdData[15:0] = {anyRxReadyN, anyTxReadyN, 2'h0, pinOe, rxReadyN, txReadyN};
    else if (wb_adr_i == `OFS_EVT_STATUS)
      rdData[`EVT_WIDTH-1:0] = evtStatus;
    else if (wb_adr_i == `OFS_EVT_ENABLE)
      rdData[`EVT_WIDTH-1:0] = evtEnable;
  end

  integer i;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (i = 0; i < 4; i = i + 1) begin
        modemControlReg[i] <= `MCR_RESET;
        fifoControl[i]     <= `FCR_RESET;
      end
      evtStatus   <= `EVT_RESET;
      evtEnable   <= `EVT_RESET;
      txReadyPrev <= 4'hF;
      rxReadyPrev <= 4'hF;
      wb_ack_o    <= 1'b0;
      wb_dat_o    <= 32'h0000_0000;
    end else begin
      wb_ack_o    <= req;
      txReadyPrev <= txReadyN;
      rxReadyPrev <= rxReadyN;
      if (req)
        wb_dat_o <= wb_we_i ? 32'h0000_0000 : rdData;
      if (wrLow & hitMcr)
        modemControlReg[chIdx] <= wb_dat_i[7:0];
      if (wrLow & hitFcr)
        fifoControl[chIdx] <= wb_dat_i[7:0];
      if (wrLow & (wb_adr_i == `OFS_EVT_ENABLE))
        evtEnable <= wb_dat_i[`EVT_WIDTH-1:0];
      // A new event beats a clear in the same cycle
      evtStatus <= (evtStatus & ~evtClr) | evtSet;
    end
  end

endmodule
